// [msd_cfg.svh]
// Constants for the motor load measure and stall detect block.
// Assumes inclusion by msd_pkg.sv and msd_top.sv by bare name.
`ifndef MSD_CFG_SVH
`define MSD_CFG_SVH
// ************
// Register byte offsets
// ************
`define MSD_ADDR_CTRL 8'h00
`define MSD_ADDR_STATUS 8'h04
`define MSD_ADDR_INT_STAT 8'h08
`define MSD_ADDR_INT_MASK 8'h0C
// ************
// Field positions
// ************
`define MSD_CTRL_OFFS_MSB 6
`define MSD_CTRL_FILT_BIT 8
`define MSD_STAT_LOAD_MSB 9
`define MSD_STAT_STALL_BIT 16
`define MSD_STAT_SA_BIT 17
`define MSD_INT_UPD_BIT 0
`define MSD_INT_STALL_BIT 1
// ************
// Reset values and arithmetic constants
// ************
`define MSD_CTRL_OFFS_RST 7'h00
`define MSD_CTRL_FILT_RST 1'h0
`define MSD_INT_RST 2'h0
`define MSD_LOAD_RST 10'h3FF
`define MSD_LOAD_MAX 13'sh03FF
`define MSD_SA_OFFSET 7'h02
`define MSD_OFFS_SHIFT 5
`define MSD_FILT_LAST 2'h3
`define MSD_FILT_FIRST 2'h0
`endif

// [msd_pkg.sv]
// Types for the motor load measure and stall detect block.
// Assumes msd_cfg.svh is on the include path.
`include "msd_cfg.svh"
package msd_pkg;
   typedef logic [9:0] msd_load_t;
   typedef logic signed [6:0] msd_offs_t;
   typedef logic signed [12:0] msd_wide_t;
   typedef logic [1:0] msd_int_t;
   typedef logic [7:0] msd_addr_t;
endpackage

// [msd_top.sv]
// Motor load measurement and stall detection with an APB register slave.
// Assumes full-step strobe and raw measurement come from logic on pclk;
// the standalone strap pin is asynchronous.
//
// Behaviour
// - A 7-bit signed offset sets the stall trip point and shifts the load value range.
// - Offset zero is neutral, positive offsets lower sensitivity, negative ones raise it.
// - With the filter bit set four measurements are averaged per update, else none.
// - The load value is a 10-bit unsigned status field from 0 to 1023.
// - The load value falls as load rises, zero meaning highest load.
// - Unfiltered, the load value refreshes once per full step.
// - The stall output is high while the load value is zero.
// - In standalone mode a fixed offset of 2 replaces the programmed one.
`timescale 1ns/1ns
`include "msd_cfg.svh"
module msd_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire msd_pkg::msd_addr_t paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Measurement source
   input wire logic fullstep_pulse,
   input wire msd_pkg::msd_load_t raw_load,
   // Pins and interrupt
   input wire logic standalone_pin,
   output logic stall_flag_out,
   output logic irq
);
   import msd_pkg::*;

   // ************
   // Functions
   // ************
   // Saturate instead of wrap so a big offset never flips load to light
   function automatic msd_load_t msd_clamp(input msd_wide_t v);
      msd_load_t r;
      if (v < 13'sh0000) begin
         r = '0;
      end else if (v > `MSD_LOAD_MAX) begin
         r = msd_load_t'(`MSD_LOAD_MAX);
      end else begin
         r = v[9:0];
      end
      return r;
   endfunction

   function automatic msd_wide_t msd_apply(input msd_load_t raw, input msd_offs_t offs);
      msd_wide_t o;
      o = msd_wide_t'(offs) <<< `MSD_OFFS_SHIFT;
      return msd_wide_t'({3'h0, raw}) + o;
   endfunction

   function automatic logic msd_hit(input msd_addr_t a);
      return (a == `MSD_ADDR_CTRL) || (a == `MSD_ADDR_STATUS) ||
             (a == `MSD_ADDR_INT_STAT) || (a == `MSD_ADDR_INT_MASK);
   endfunction

   // ************
   // Strap synchroniser
   // ************
   logic sa_s1_r, sa_s2_r, sa_s3_r, sa_r;
   logic sa_nxt;

   always_comb begin
      sa_nxt = sa_r;
      if (sa_s2_r == sa_s3_r) begin
         sa_nxt = sa_s3_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sa_s1_r <= 1'b0;
         sa_s2_r <= 1'b0;
         sa_s3_r <= 1'b0;
         sa_r <= 1'b0;
      end else begin
         sa_s1_r <= standalone_pin;
         sa_s2_r <= sa_s1_r;
         sa_s3_r <= sa_s2_r;
         sa_r <= sa_nxt;
      end
   end

   // ************
   // APB decode
   // ************
   logic acc_ph, wr_ph, setup_ph;
   assign acc_ph = psel & penable;
   assign wr_ph = acc_ph & pwrite & msd_hit(paddr);
   assign setup_ph = psel & ~penable;
   // Zero wait state: read data is built during setup
   assign pready = 1'b1;
   assign pslverr = acc_ph & ~msd_hit(paddr);

   // ************
   // Control registers
   // ************
   msd_offs_t offs_r, offs_nxt;
   logic filt_r, filt_nxt;
   msd_int_t mask_r, mask_nxt;

   always_comb begin
      offs_nxt = offs_r;
      filt_nxt = filt_r;
      mask_nxt = mask_r;
      if (wr_ph && paddr == `MSD_ADDR_CTRL) begin
         if (pstrb[0]) begin
            offs_nxt = pwdata[`MSD_CTRL_OFFS_MSB:0];
         end
         if (pstrb[1]) begin
            filt_nxt = pwdata[`MSD_CTRL_FILT_BIT];
         end
      end
      if (wr_ph && paddr == `MSD_ADDR_INT_MASK && pstrb[0]) begin
         mask_nxt = pwdata[`MSD_INT_STALL_BIT:`MSD_INT_UPD_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         offs_r <= `MSD_CTRL_OFFS_RST;
         filt_r <= `MSD_CTRL_FILT_RST;
         mask_r <= `MSD_INT_RST;
      end else begin
         offs_r <= offs_nxt;
         filt_r <= filt_nxt;
         mask_r <= mask_nxt;
      end
   end

   // ************
   // Measurement path
   // ************
   msd_offs_t offs_eff;
   msd_load_t load_r, load_nxt;
   logic [11:0] acc_r, acc_nxt;
   logic [1:0] phase_r, phase_nxt;
   logic stall_r, stall_nxt;
   logic upd_ev;
   logic [11:0] sum4;

   // Strap overrides the register so a pin-only board still trips
   assign offs_eff = sa_r ? msd_offs_t'(`MSD_SA_OFFSET) : offs_r;
   assign sum4 = acc_r + {2'h0, raw_load};

   always_comb begin
      load_nxt = load_r;
      acc_nxt = acc_r;
      phase_nxt = phase_r;
      upd_ev = 1'b0;
      if (fullstep_pulse) begin
         if (filt_r) begin
            // Phase zero restarts the sum, so toggling the bit costs one window
            acc_nxt = (phase_r == `MSD_FILT_FIRST) ? {2'h0, raw_load} : sum4;
            phase_nxt = phase_r + 2'h1;
            if (phase_r == `MSD_FILT_LAST) begin
               load_nxt = msd_clamp(msd_apply(sum4[11:2], offs_eff));
               phase_nxt = `MSD_FILT_FIRST;
               acc_nxt = '0;
               upd_ev = 1'b1;
            end
         end else begin
            // Offset added: positive keeps value off zero longer
            load_nxt = msd_clamp(msd_apply(raw_load, offs_eff));
            phase_nxt = `MSD_FILT_FIRST;
            acc_nxt = '0;
            upd_ev = 1'b1;
         end
      end
      stall_nxt = (load_nxt == '0);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_r <= `MSD_LOAD_RST;
         acc_r <= '0;
         phase_r <= `MSD_FILT_FIRST;
         stall_r <= 1'b0;
      end else begin
         load_r <= load_nxt;
         acc_r <= acc_nxt;
         phase_r <= phase_nxt;
         stall_r <= stall_nxt;
      end
   end

   assign stall_flag_out = stall_r;

   // ************
   // Interrupts
   // ************
   msd_int_t ist_r, ist_nxt, ev;
   logic irq_r, irq_nxt;

   assign ev = {stall_nxt & ~stall_r, upd_ev};

   always_comb begin
      ist_nxt = ist_r;
      if (wr_ph && paddr == `MSD_ADDR_INT_STAT && pstrb[0]) begin
         ist_nxt = ist_nxt & ~pwdata[`MSD_INT_STALL_BIT:`MSD_INT_UPD_BIT];
      end
      // Set after clear: an event in the clear cycle survives
      ist_nxt = ist_nxt | ev;
      irq_nxt = |(ist_nxt & mask_nxt);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_r <= `MSD_INT_RST;
         irq_r <= 1'b0;
      end else begin
         ist_r <= ist_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign irq = irq_r;

   // ************
   // Read data
   // ************
   logic [31:0] rd_r, rd_nxt;

   always_comb begin
      rd_nxt = rd_r;
      if (setup_ph && !pwrite) begin
         rd_nxt = '0;
         unique case (paddr)
            `MSD_ADDR_CTRL: begin
               rd_nxt[`MSD_CTRL_OFFS_MSB:0] = offs_r;
               rd_nxt[`MSD_CTRL_FILT_BIT] = filt_r;
            end
            `MSD_ADDR_STATUS: begin
               rd_nxt[`MSD_STAT_LOAD_MSB:0] = load_r;
               rd_nxt[`MSD_STAT_STALL_BIT] = stall_r;
               rd_nxt[`MSD_STAT_SA_BIT] = sa_r;
            end
            `MSD_ADDR_INT_STAT: begin
               rd_nxt[`MSD_INT_STALL_BIT:`MSD_INT_UPD_BIT] = ist_r;
            end
            `MSD_ADDR_INT_MASK: begin
               rd_nxt[`MSD_INT_STALL_BIT:`MSD_INT_UPD_BIT] = mask_r;
            end
            default: begin
               rd_nxt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_r <= '0;
      end else begin
         rd_r <= rd_nxt;
      end
   end

   assign prdata = rd_r;

endmodule

// [msd_src_model.sv]
// Step source model: full-step strobe with raw load sample.
// Assumes the block samples raw_load only in the strobe cycle.
`timescale 1ns/1ns
module msd_src_model import msd_pkg::*; (
   // Strobe and sample
   input wire logic pclk,
   output logic fullstep_pulse,
   output msd_load_t raw_load
);
   initial begin
      fullstep_pulse = 1'b0;
      raw_load = 10'h2AA;
   end
   // Sample scrambled outside the strobe, so no stale value passes
   task automatic step(input msd_load_t v);
      @(posedge pclk);
      fullstep_pulse <= 1'b1;
      raw_load <= v;
      @(posedge pclk);
      fullstep_pulse <= 1'b0;
      raw_load <= ~v;
   endtask
endmodule

// [msd_top_assertions.sv]
// Checker of msd_top port behaviour.
// Assumes the bind below; sees only msd_top ports.
`timescale 1ns/1ns
module msd_top_assertions import msd_pkg::*; (
   // Bus
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input msd_addr_t paddr,
   input logic [31:0] pwdata,
   input logic [3:0] pstrb,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   // Measurement
   input logic fullstep_pulse,
   input msd_load_t raw_load,
   input logic standalone_pin,
   input logic stall_flag_out
);
   msd_offs_t offs_r, offs_nxt;
   logic filt_r, filt_nxt;
   msd_wide_t sum;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_comb begin
      offs_nxt = offs_r;
      filt_nxt = filt_r;
      if (psel && penable && pwrite && paddr == 8'h00) begin
         if (pstrb[0]) offs_nxt = pwdata[6:0];
         if (pstrb[1]) filt_nxt = pwdata[8];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         offs_r <= 7'h00;
         filt_r <= 1'b0;
      end else begin
         offs_r <= offs_nxt;
         filt_r <= filt_nxt;
      end
   end
   // Raw pin is trusted only when steady longer than the sync delay
   assign sum = msd_wide_t'({3'h0, raw_load}) +
      (msd_wide_t'(standalone_pin ? 7'sh02 : offs_r) <<< 5);
   sequence s_rd_status;
      psel && penable && !pwrite && paddr == 8'h04;
   endsequence
   a_stall_calc: assert property (
      fullstep_pulse && !filt_r && standalone_pin == $past(standalone_pin, 8)
      |=> stall_flag_out == ($past(sum) <= 13'sh0000)) else $error("stall level wrong");
   a_stall_hold: assert property ($changed(stall_flag_out) |-> $past(fullstep_pulse))
      else $error("stall moved without step");
   a_status_flag: assert property (s_rd_status |-> prdata[16] == (prdata[9:0] == 10'h000))
      else $error("stall bit disagrees with load");
   a_status_width: assert property (
      s_rd_status |-> prdata[15:10] == 6'h00 && prdata[31:18] == 14'h0000)
      else $error("status spare bits set");
   a_unmap_err: assert property (psel && penable && (paddr > 8'h0C || paddr[1:0] != 2'h0)
      |-> pslverr) else $error("no error on unmapped");
   a_map_ok: assert property (psel && penable && paddr <= 8'h0C && paddr[1:0] == 2'h0
      |-> !pslverr) else $error("error on mapped");
   a_pready_high: assert property (psel && penable |-> pready) else $error("wait state");
   a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved");
endmodule
bind msd_top msd_top_assertions msd_top_assertions_i(.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .fullstep_pulse,
   .raw_load, .standalone_pin, .stall_flag_out);

// [tb.sv]
// Self-checking bench for msd_top over APB with a step source model.
// Assumes msd_pkg, msd_src_model and the checker compile first.
`timescale 1ns/1ns
module tb;
   import msd_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, standalone_pin = 0;
   msd_addr_t paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, err, fullstep_pulse, stall_flag_out, irq;
   msd_load_t raw_load;
   int n_fail = 0, comparisons = 0;
   msd_top msd_top_i(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .fullstep_pulse, .raw_load, .standalone_pin,
      .stall_flag_out, .irq);
   msd_src_model src_i(.pclk, .fullstep_pulse, .raw_load);
   initial forever #2 pclk = ~pclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input msd_addr_t a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input msd_addr_t a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   function automatic logic [31:0] st(input msd_load_t v, input logic s, input logic sa);
      return {14'h0000, sa, s, 6'h00, v};
   endfunction
   task automatic t_reset;
      rdc(8'h00, 32'h0);
      rdc(8'h04, st(10'h3FF, 1'b0, 1'b0));
      rdc(8'h08, 32'h0);
      rdc(8'h10, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("t_reset done");
   endtask
   task automatic t_unfilt;
      int o[6] = '{0, 0, -63, 63, 1, -1};
      int r[6] = '{0, 500, 500, 0, 5, 40};
      int e[6] = '{0, 500, 0, 1023, 37, 8};
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, 8'h00, {25'h0, 7'(o[i])});
         src_i.step(10'(r[i]));
         rdc(8'h04, st(10'(e[i]), e[i] == 0, 1'b0));
         chk({31'h0, stall_flag_out}, {31'h0, e[i] == 0});
      end
      $display("t_unfilt done");
   endtask
   task automatic t_irq;
      apb(1'b1, 8'h08, 32'h3);
      apb(1'b1, 8'h0C, 32'h3);
      src_i.step(10'h000);
      rdc(8'h08, 32'h3);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, 8'h08, 32'h1);
      rdc(8'h08, 32'h2);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, 8'h08, 32'h2);
      rdc(8'h08, 32'h0);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, 8'h0C, 32'h0);
      src_i.step(10'h12C);
      rdc(8'h08, 32'h1);
      chk({31'h0, irq}, 32'h0);
      $display("t_irq done");
   endtask
   task automatic t_filter;
      apb(1'b1, 8'h00, 32'h100);
      src_i.step(10'h064);
      src_i.step(10'h0C8);
      src_i.step(10'h12C);
      rdc(8'h04, st(10'h10C, 1'b0, 1'b0));
      src_i.step(10'h191);
      rdc(8'h04, st(10'h0FA, 1'b0, 1'b0));
      $display("t_filter done");
   endtask
   task automatic t_sa;
      apb(1'b1, 8'h00, 32'h0);
      standalone_pin <= 1'b1;
      repeat (8) @(posedge pclk);
      src_i.step(10'h000);
      rdc(8'h04, st(10'h040, 1'b0, 1'b1));
      standalone_pin <= 1'b0;
      $display("t_sa done");
   endtask
   task automatic t_strb;
      pstrb <= 4'h2;
      apb(1'b1, 8'h00, 32'h17F);
      pstrb <= 4'hF;
      rdc(8'h00, 32'h100);
      pstrb <= 4'h1;
      apb(1'b1, 8'h00, 32'h005);
      pstrb <= 4'hF;
      rdc(8'h00, 32'h105);
      $display("t_strb done");
   endtask
   task automatic conclude;
      $display("%0d comparisons, %0d failures", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_unfilt;
      t_irq;
      t_filter;
      t_sa;
      t_strb;
      conclude;
   end
   initial begin
      repeat (5000) @(posedge pclk);
      n_fail++;
      conclude;
   end
endmodule
